// file: include/fault_sup_if.sv
/*
  Interfaces between the supervisor and its counter and timer leaves.
  Assumes one clock; tick is a one-cycle 1 ms enable.
*/
`timescale 1ns/100ps
`default_nettype none
interface load_if;
  logic tick; // Millisecond enable
  logic over; // Current above continuous rating
  logic [6:0] pct; // Load in percent
  modport src(output tick, output over, input pct);
  modport cnt(input tick, input over, output pct);
endinterface
interface timer_if;
  logic tick; // Millisecond enable
  logic run; // Condition present
  logic [15:0] limit; // Delay in ms
  logic done; // Delay elapsed
  modport src(output tick, output run, output limit, input done);
  modport tmr(input tick, input run, input limit, output done);
endinterface
`default_nettype wire

// file: include/fault_sup_pkg.sv
/*
  Constants, types and helper functions of the drive fault supervisor.
  Assumes a 100 MHz system clock and a 32-bit APB register bus.
*/
`default_nettype none
package fault_sup_pkg;
  // ************************************
  // Timing
  // ************************************
  localparam int CLK_MHZ = 100;
  localparam int TICK_US = 1000;
  localparam int TICK_CYC = TICK_US * CLK_MHZ;
  localparam logic [15:0] OC_WARN_MS = 16'h05DC;
  localparam logic [15:0] BLINK_MS = 16'h01F4;
  localparam logic [15:0] STEP_MS = 16'h000A;
  // ************************************
  // Load thresholds in percent
  // ************************************
  localparam logic [6:0] PCT_WARN_INV = 7'h62;
  localparam logic [6:0] PCT_FULL = 7'h64;
  localparam logic [6:0] PCT_RESET = 7'h5A;
  localparam logic [6:0] PCT_WARN_MOT = 7'h5A;
  // ************************************
  // Register map and fields
  // ************************************
  localparam logic [7:0] OFS_CFG = 8'h00;
  localparam logic [7:0] OFS_DLY = 8'h04;
  localparam logic [7:0] OFS_UVD = 8'h08;
  localparam logic [7:0] OFS_CMD = 8'h0C;
  localparam logic [7:0] OFS_STAT = 8'h10;
  localparam logic [7:0] OFS_FLT = 8'h14;
  localparam logic [7:0] OFS_LOAD = 8'h18;
  localparam int CFG_LZ = 0;
  localparam int CFG_MAINS = 2;
  localparam int CFG_MOT = 4;
  localparam int CFG_THERM = 6;
  localparam int CFG_TQTRIP = 8;
  localparam int CFG_BRAKE = 9;
  localparam int CFG_AUTO = 10;
  localparam logic [31:0] CFG_RST = 32'h0000_0000;
  localparam logic [31:0] DLY_RST = 32'h01F4_01F4;
  localparam logic [15:0] UVD_RST = 16'h03E8;
  // Response modes of configurable faults
  localparam logic [1:0] RESP_OFF = 2'h0;
  localparam logic [1:0] RESP_TRIP = 2'h2;
  // Fault numbers double as bit positions
  localparam int F_LOCK = 16;
  typedef enum logic [1:0] {
    CLS_NONE = 2'h0, CLS_WARN = 2'h1, CLS_ALARM = 2'h2, CLS_LOCK = 2'h3
  } class_type;
  typedef enum logic [1:0] {ST_RUN, ST_TRIP, ST_LOCK, ST_HOLD} state_type;
  // Lowest set fault number, zero when none
  function automatic logic [7:0] first_set(input logic [16:0] v);
    logic [7:0] n;
    n = 8'h00;
    for (int i = 16; i > 0; i--) begin
      if (v[i]) begin
        n = 8'(i);
      end
    end
    return n;
  endfunction
  // Grade a configurable fault: {alarm, warning}
  function automatic logic [1:0] grade(input logic [1:0] m, input logic c);
    return {c && (m == RESP_TRIP), c && (m != RESP_OFF)};
  endfunction
endpackage
`default_nettype wire

// file: rtl/delay_timer.sv
/*
  Delay timer: done once run has held for limit milliseconds.
  Assumes run drops when the condition goes away.
*/
`timescale 1ns/100ps
`default_nettype none
module delay_timer
  import fault_sup_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic rst_b_i,
  timer_if.tmr t
);
  typedef struct packed {
    logic [15:0] cnt; // Elapsed ms
    logic done; // Expired flag
  } dt_type;
  dt_type s_q, s_d;
  // Restart from zero whenever the condition lapses
  always_comb begin
    s_d = s_q;
    if (!t.run) begin
      s_d = '0;
    end else if (s_q.cnt >= t.limit) begin
      s_d.done = 1'b1;
    end else if (t.tick) begin
      s_d.cnt = s_q.cnt + 16'h0001;
    end
  end
  // State register
  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end
  assign t.done = s_q.done;
  done_run_a: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    s_q.done |-> $past(t.run)) else $error("timer done without condition");
endmodule
`default_nettype wire

// file: rtl/drive_fault_supervisor.sv
/*
  Drive fault supervisor: grades detector levels into warnings, alarms,
  trips and trip locks, drives panel lights and the fault number, and
  offers configuration and status over APB.
  Assumes detector and key inputs are synchronous to ref_clk_i, and that
  lock_mem_i is a retained copy of lock_flag_o from before power-down.
*/
// Design decisions made here: register access over APB and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none
module drive_fault_supervisor
  import fault_sup_pkg::*;
#(
  parameter int TICK_CYCLES = TICK_CYC
) (
  input wire logic ref_clk_i,
  input wire logic rst_b_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic ref_low_i,
  input wire logic ain_low_i,
  input wire logic mains_fault_i,
  input wire logic dc_high_i,
  input wire logic dc_low_i,
  input wire logic dc_ov_i,
  input wire logic dc_uv_i,
  input wire logic aux_supply_i,
  input wire logic inv_over_i,
  input wire logic motor_over_i,
  input wire logic thermistor_hot_i,
  input wire logic torque_lim_i,
  input wire logic peak_cur_i,
  input wire logic short_circuit_i,
  input wire logic panel_reset_i,
  input wire logic dig_reset_i,
  input wire logic lock_mem_i,
  output logic drive_en_o,
  output logic warn_led_o,
  output logic alarm_led_o,
  output logic [7:0] fault_num_o,
  output logic [1:0] fault_class_o,
  output logic lock_flag_o
);

  // ************************************
  // State
  // ************************************
  // One record holds every flip-flop of the supervisor outside its load counters and delay timers
  typedef struct packed {
    state_type st; // Supervisor state
    logic boot; // First cycle after reset release
    logic oc_trip; // Trip was caused by overcurrent
    logic [7:0] num; // Shown fault number
    class_type cls; // Shown fault class
    logic [31:0] cfg; // Response configuration
    logic [31:0] dly; // Torque and overvoltage delays
    logic [15:0] uvd; // Undervoltage delay
    logic [31:0] prdata; // Read data
    logic pready; // Access phase answer
    logic pslverr; // Unmapped address
    logic [16:0] tick_cnt; // Tick divider
    logic tick; // Millisecond enable
    logic [15:0] blink_cnt; // Flash divider
    logic blink; // Flash phase
    logic drive_en; // Output stage enabled
    logic warn_led; // Warning light
    logic alarm_led; // Alarm light
    logic lock_flag; // Lock held, to be retained
  } sup_type;
  sup_type s_q, s_d;

  // Combinational helpers, rebuilt every cycle
  logic [16:0] w_vec; // Active warnings by number
  logic [16:0] a_vec; // Active alarms by number
  logic [1:0] g_lz, g_mains, g_therm; // Graded configurable faults
  logic cause_gone; // Nothing holds the trip
  logic ser_reset; // Serial reset command this cycle
  logic ext_reset; // Reset from input, serial or auto
  logic rq_any; // Any reset request
  logic wr_en; // APB write completes
  logic [15:0] lim [4]; // Timer limits
  logic [3:0] run; // Timer run levels
  logic [3:0] done; // Timer expiries
  logic [1:0] over; // Load counter over-rating levels
  logic [6:0] pct [2]; // Inverter and motor load

  // ************************************
  // Load counters and delay timers
  // ************************************
  // Index 0 is the inverter, index 1 the motor
  load_if ld [2] ();
  // All timers share the millisecond tick
  timer_if tm [4] ();
  assign over[0] = inv_over_i;
  assign over[1] = motor_over_i;
  // Overvoltage, undervoltage, torque and peak current delays
  assign run[0] = dc_ov_i;
  assign run[1] = dc_uv_i && !aux_supply_i;
  assign run[2] = torque_lim_i && s_q.cfg[CFG_TQTRIP];
  assign run[3] = peak_cur_i;
  // Only the overcurrent delay is fixed
  assign lim[0] = s_q.dly[15:0];
  assign lim[1] = s_q.uvd;
  assign lim[2] = s_q.dly[31:16];
  assign lim[3] = OC_WARN_MS;

  // One counter per load, both stepped by the same tick
  for (genvar i = 0; i < 2; i++) begin : g_load
    assign ld[i].tick = s_q.tick;
    assign ld[i].over = over[i];
    assign pct[i] = ld[i].pct;
    thermal_counter u_cnt (
      .ref_clk_i(ref_clk_i),
      .rst_b_i(rst_b_i),
      .ld(ld[i])
    );
  end

  // A lapse of the condition restarts a timer from zero
  for (genvar i = 0; i < 4; i++) begin : g_tmr
    assign tm[i].tick = s_q.tick;
    assign tm[i].run = run[i];
    assign tm[i].limit = lim[i];
    assign done[i] = tm[i].done;
    delay_timer u_tmr (
      .ref_clk_i(ref_clk_i),
      .rst_b_i(rst_b_i),
      .t(tm[i])
    );
  end

  // ************************************
  // Fault grading
  // ************************************
  // Build warning and alarm vectors from detector levels
  always_comb begin
    g_lz = grade(s_q.cfg[CFG_LZ+:2], ain_low_i);
    g_mains = grade(s_q.cfg[CFG_MAINS+:2], mains_fault_i);
    g_therm = grade(s_q.cfg[CFG_THERM+:2], thermistor_hot_i);
    w_vec = '0;
    a_vec = '0;
    w_vec[1] = ref_low_i;
    {a_vec[2], w_vec[2]} = g_lz;
    {a_vec[4], w_vec[4]} = g_mains;
    w_vec[5] = dc_high_i;
    w_vec[6] = dc_low_i;
    w_vec[7] = dc_ov_i;
    a_vec[7] = done[0];
    w_vec[8] = dc_uv_i;
    a_vec[8] = done[1];
    w_vec[9] = pct[0] >= PCT_WARN_INV;
    a_vec[9] = pct[0] >= PCT_FULL;
    w_vec[10] = pct[1] > PCT_WARN_MOT && s_q.cfg[CFG_MOT+:2] != RESP_OFF;
    a_vec[10] = pct[1] >= PCT_FULL && s_q.cfg[CFG_MOT+:2] == RESP_TRIP;
    {a_vec[11], w_vec[11]} = g_therm;
    w_vec[12] = torque_lim_i;
    a_vec[12] = done[2];
    w_vec[13] = peak_cur_i;
    a_vec[13] = done[3];
    a_vec[F_LOCK] = short_circuit_i;
  end

  // Inverter overload also blocks reset until the load falls below 90
  assign cause_gone = (a_vec == '0) && (pct[0] < PCT_RESET);

  // Serial reset is bit 0 written to the command word
  assign wr_en = psel_i && penable_i && s_q.pready && pwrite_i;
  assign ser_reset = wr_en && (paddr_i == OFS_CMD) && pwdata_i[0];
  // Auto reset is a request that never drops
  assign ext_reset = dig_reset_i || ser_reset || s_q.cfg[CFG_AUTO];
  assign rq_any = panel_reset_i || ext_reset;

  // ************************************
  // Next state
  // ************************************
  always_comb begin
    s_d = s_q;
    s_d.boot = 1'b0;

    // Millisecond enable and flash phase
    s_d.tick = 1'b0;
    s_d.tick_cnt = s_q.tick_cnt + 17'h00001;
    if (s_q.tick_cnt == 17'(TICK_CYCLES - 1)) begin
      s_d.tick_cnt = 17'h00000;
      s_d.tick = 1'b1;
    end
    if (s_q.tick) begin
      s_d.blink_cnt = s_q.blink_cnt + 16'h0001;
      if (s_q.blink_cnt == BLINK_MS - 16'h0001) begin
        s_d.blink_cnt = 16'h0000;
        s_d.blink = !s_q.blink;
      end
    end

    // Supervisor state machine
    case (s_q.st)
      ST_RUN: begin
        // Warnings alone keep the drive running, shown live
        s_d.num = first_set(w_vec);
        s_d.cls = (w_vec != '0) ? CLS_WARN : CLS_NONE;
      end
      ST_TRIP: begin
        // Overcurrent trip takes external reset only with brake control
        if (cause_gone && (panel_reset_i ||
            (ext_reset && (!s_q.oc_trip || s_q.cfg[CFG_BRAKE])))) begin
          s_d.st = ST_RUN;
        end
      end
      ST_LOCK: begin
        s_d.st = ST_LOCK;
      end
      ST_HOLD: begin
        if (cause_gone && rq_any) begin
          s_d.st = ST_RUN;
        end
      end
      default: begin
        s_d.st = ST_TRIP;
      end
    endcase

    // Retained lock turns into a restart block after power-up
    if (s_q.boot && lock_mem_i) begin
      s_d.st = ST_HOLD;
      s_d.num = 8'h00;
      s_d.cls = CLS_LOCK;
    end

    // New alarms: latch number and class, lock outranks trip
    if (a_vec[F_LOCK] && s_q.st != ST_LOCK) begin
      s_d.st = ST_LOCK;
      s_d.num = 8'(F_LOCK);
      s_d.cls = CLS_LOCK;
    end else if (a_vec != '0 && (s_d.st == ST_RUN || s_d.st == ST_HOLD)) begin
      s_d.st = ST_TRIP;
      s_d.num = first_set(a_vec);
      s_d.cls = CLS_ALARM;
      s_d.oc_trip = a_vec[13];
    end

    // Outputs follow the next state so they change with it
    s_d.drive_en = s_d.st == ST_RUN;
    s_d.lock_flag = s_d.st == ST_LOCK;
    s_d.warn_led = (s_d.st == ST_RUN && w_vec != '0) || s_d.st == ST_LOCK;
    s_d.alarm_led = s_d.st != ST_RUN && s_d.blink;

    // APB: answer in the access phase, zero wait states
    s_d.pready = psel_i && !penable_i;
    s_d.pslverr = 1'b0;
    // Read data is taken in setup, so it stands in access
    if (psel_i && !penable_i) begin
      case (paddr_i)
        OFS_CFG: s_d.prdata = s_q.cfg;
        OFS_DLY: s_d.prdata = s_q.dly;
        OFS_UVD: s_d.prdata = {16'h0000, s_q.uvd};
        OFS_CMD: s_d.prdata = 32'h0000_0000;
        OFS_STAT: s_d.prdata = {10'h000, s_q.st, 3'h0, w_vec};
        OFS_FLT: s_d.prdata = {22'h000000, s_q.cls, s_q.num};
        OFS_LOAD: s_d.prdata = {17'h00000, pct[1], 1'b0, pct[0]};
        default: begin
          s_d.prdata = 32'h0000_0000;
          s_d.pslverr = 1'b1;
        end
      endcase
    end

    // Writes land at the end of the access phase
    if (wr_en) begin
      case (paddr_i)
        OFS_CFG: s_d.cfg = pwdata_i;
        OFS_DLY: s_d.dly = pwdata_i;
        OFS_UVD: s_d.uvd = pwdata_i[15:0];
        default: begin
        end
      endcase
    end
  end

  // State register
  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      s_q <= '0;
      s_q.boot <= 1'b1;
      s_q.cfg <= CFG_RST;
      s_q.dly <= DLY_RST;
      s_q.uvd <= UVD_RST;
    end else begin
      s_q <= s_d;
    end
  end

  // Every output is a register bit, never a decode
  assign prdata_o = s_q.prdata;
  assign pready_o = s_q.pready;
  assign pslverr_o = s_q.pslverr;
  assign drive_en_o = s_q.drive_en;
  assign warn_led_o = s_q.warn_led;
  assign alarm_led_o = s_q.alarm_led;
  assign fault_num_o = s_q.num;
  assign fault_class_o = s_q.cls;
  assign lock_flag_o = s_q.lock_flag;

  // ************************************
  // Checks
  // ************************************
  // Properties watch registered state and outputs
  alarm_stops_a: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    (a_vec != '0) |=> !drive_en_o && s_q.st != ST_RUN) else $error("alarm left drive on");
  coast_a: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    (s_q.st != ST_RUN) |-> !drive_en_o) else $error("drive enabled while faulted");
  early_reset_a: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    (s_q.st == ST_TRIP && !cause_gone) |=> s_q.st != ST_RUN) else $error("trip cleared early");
  lock_kept_a: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    (s_q.st == ST_LOCK) |=> s_q.st == ST_LOCK) else $error("trip lock left");
  hold_wait_a: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    (s_q.st == ST_HOLD && !rq_any) |=> s_q.st != ST_RUN) else $error("restart without reset");
  lock_lights_a: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    (s_q.st == ST_LOCK) |-> warn_led_o && fault_class_o == CLS_LOCK) else $error("lock display");
  inv_reset_a: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    (s_q.st == ST_TRIP && pct[0] >= PCT_RESET) |=> s_q.st != ST_RUN) else $error("reset above 90");
  num_latched_a: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    (s_q.st == ST_TRIP ##1 s_q.st == ST_TRIP) |-> $stable(fault_num_o)) else $error("number moved");
  oc_key_a: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    (s_q.st == ST_TRIP && s_q.oc_trip && !s_q.cfg[CFG_BRAKE] && !panel_reset_i) |=>
    s_q.st != ST_RUN) else $error("overcurrent trip cleared externally");
  backup_hold_a: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    (dc_uv_i && aux_supply_i) |=> !done[1]) else $error("undervoltage timed with back-up");

  trip_c: cover property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    s_q.st == ST_RUN ##1 s_q.st == ST_TRIP ##[1:50] s_q.st == ST_RUN);
  lock_c: cover property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    s_q.st == ST_TRIP ##1 s_q.st == ST_LOCK);
  hold_c: cover property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    s_q.st == ST_HOLD ##1 s_q.st == ST_RUN);
  oc_clear_c: cover property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    s_q.st == ST_TRIP && s_q.oc_trip ##1 s_q.st == ST_RUN);
endmodule
`default_nettype wire

// file: rtl/thermal_counter.sv
/*
  Thermal load counter in whole percent, stepped every STEP_MS.
  Assumes the tick and over level come from the supervisor.
*/
`timescale 1ns/100ps
`default_nettype none
module thermal_counter
  import fault_sup_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic rst_b_i,
  load_if.cnt ld
);
  typedef struct packed {
    logic [15:0] step; // Ticks since last step
    logic [6:0] pct; // Load level
  } tc_type;
  tc_type s_q, s_d;
  // Saturating up/down count, so recovery time mirrors overload time
  always_comb begin
    s_d = s_q;
    if (ld.tick) begin
      if (s_q.step == STEP_MS - 16'h0001) begin
        s_d.step = 16'h0000;
        if (ld.over && s_q.pct < PCT_FULL) begin
          s_d.pct = s_q.pct + 7'h01;
        end else if (!ld.over && s_q.pct != 7'h00) begin
          s_d.pct = s_q.pct - 7'h01;
        end
      end else begin
        s_d.step = s_q.step + 16'h0001;
      end
    end
  end
  // State register
  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end
  assign ld.pct = s_q.pct;
  rise_cause_a: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    (s_q.pct > $past(s_q.pct)) |-> $past(ld.over)) else $error("load rose while under rating");
endmodule
`default_nettype wire

// file: testbench/drive_fault_supervisor_tb_top.sv
/*
  Self-checking bench of the drive fault supervisor.
  Assumes the panel host model and a 4-cycle millisecond tick.
*/
`timescale 1ns/100ps
`default_nettype none
module drive_fault_supervisor_tb_top;
  import fault_sup_pkg::*;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic lock_mem = 1'b0;
  logic dig = 1'b0;
  logic [3:0] wv = 4'h0; // Ref low, DC high, DC low, torque
  logic [2:0] cf = 3'h0; // Live zero, mains, thermistor
  logic ov = 1'b0, uv = 1'b0, aux = 1'b0, inv = 1'b0;
  logic mot = 1'b0, peak = 1'b0, shrt = 1'b0;
  logic psel, pen, pwr, prdy, perr, key, en, wl, al, lk;
  logic [7:0] pa, num;
  logic [31:0] pwd, prd;
  logic [1:0] cls;
  int fail_count = 0;
  int total_checks = 0;
  panel_host u_host (.ref_clk_i(clk), .prdata_i(prd), .pready_i(prdy),
    .pslverr_i(perr), .psel_o(psel), .penable_o(pen), .pwrite_o(pwr),
    .paddr_o(pa), .pwdata_o(pwd), .panel_reset_o(key));
  // Short tick keeps the long delays affordable
  drive_fault_supervisor #(.TICK_CYCLES(4)) dut (.ref_clk_i(clk),
    .rst_b_i(rst_b), .psel_i(psel), .penable_i(pen), .pwrite_i(pwr),
    .paddr_i(pa), .pwdata_i(pwd), .prdata_o(prd), .pready_o(prdy),
    .pslverr_o(perr), .ref_low_i(wv[0]), .ain_low_i(cf[0]),
    .mains_fault_i(cf[1]), .dc_high_i(wv[1]), .dc_low_i(wv[2]),
    .dc_ov_i(ov), .dc_uv_i(uv), .aux_supply_i(aux), .inv_over_i(inv),
    .motor_over_i(mot), .thermistor_hot_i(cf[2]), .torque_lim_i(wv[3]),
    .peak_cur_i(peak), .short_circuit_i(shrt), .panel_reset_i(key),
    .dig_reset_i(dig), .lock_mem_i(lock_mem), .drive_en_o(en),
    .warn_led_o(wl), .alarm_led_o(al), .fault_num_o(num),
    .fault_class_o(cls), .lock_flag_o(lk));
  initial begin
    forever #5 clk = ~clk;
  end
  // ************************************
  // Shared tasks
  // ************************************
  task automatic summarize();
    $display("checks %0d failures %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    total_checks++;
    if (g !== e) begin
      fail_count++;
      $display("CHECK FAILED %0t got %0h expected %0h", $time, g, e);
    end
  endtask
  task automatic tmo();
    fail_count++;
    $display("CHECK FAILED %0t wait ran out", $time);
    summarize();
  endtask
  // Settle a few cycles, sample just after the edge
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic rw(input logic w, input logic [7:0] a, input logic [31:0] d,
    output logic [31:0] r, output logic e);
    logic [1:0] st;
    u_host.apb(w, a, d, r, st);
    e = st[0];
    if (st[1]) tmo();
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    rw(1'b1, a, d, r, e);
  endtask
  task automatic pulse_dig();
    @(posedge clk) dig <= 1'b1;
    @(posedge clk) dig <= 1'b0;
  endtask
  task automatic sts(input logic e, input logic [1:0] c, input logic [7:0] n);
    chk({en, cls, num}, {e, c, n});
  endtask
  // Bounded wait for a shown class and number; t counts cycles
  task automatic wt(input logic [1:0] c, input logic [7:0] n, input int b,
    output int t);
    for (t = 1; t <= b; t++) begin
      @(posedge clk);
      #1;
      if (cls === c && num === n) break;
    end
    if (t > b) tmo();
  endtask
  // ************************************
  // Scenarios
  // ************************************
  task automatic t_regs();
    logic [7:0] a [4] = '{OFS_CFG, OFS_DLY, OFS_UVD, 8'h40};
    logic [31:0] x [4] = '{CFG_RST, DLY_RST, {16'h0000, UVD_RST}, 32'h0};
    logic [31:0] r;
    logic e;
    // Last entry is unmapped and must be refused
    for (int k = 0; k < 4; k++) begin
      rw(1'b0, a[k], 32'h0, r, e);
      chk(r, x[k]);
      chk(e, k == 3);
    end
  endtask
  task automatic t_warn();
    logic [7:0] n [4] = '{8'h01, 8'h05, 8'h06, 8'h0C};
    for (int k = 0; k < 4; k++) begin
      @(posedge clk) wv <= 4'(1 << k);
      cyc(2);
      sts(1'b1, CLS_WARN, n[k]);
      chk({wl, al}, 2'b10);
      @(posedge clk) wv <= 4'h0;
    end
    cyc(2);
    sts(1'b1, CLS_NONE, 8'h00);
  endtask
  task automatic t_cfg();
    logic [7:0] n [3] = '{8'h02, 8'h04, 8'h0B};
    // Warning mode first, then trip mode, for each input
    for (int m = 0; m < 2; m++) begin
      wr(OFS_CFG, m == 0 ? 32'h45 : 32'h8A);
      for (int k = 0; k < 3; k++) begin
        @(posedge clk) cf <= 3'(1 << k);
        cyc(2);
        sts(m == 0, m == 0 ? CLS_WARN : CLS_ALARM, n[k]);
        if (m == 1) begin
          wr(OFS_CMD, 32'h1);
          cyc(2);
          sts(1'b0, CLS_ALARM, n[k]);
        end
        @(posedge clk) cf <= 3'h0;
        if (m == 1) wr(OFS_CMD, 32'h1);
        cyc(2);
        sts(1'b1, CLS_NONE, 8'h00);
      end
    end
    wr(OFS_CFG, 32'h0);
  endtask
  task automatic t_ov();
    int t;
    int h = 0;
    wr(OFS_DLY, 32'h01F4_0005);
    @(posedge clk) ov <= 1'b1;
    wt(CLS_WARN, 8'h07, 3, t);
    wt(CLS_ALARM, 8'h07, 40, t);
    chk(t >= 18 && t <= 26, 1);
    // One flash period is two 500 ms phases of 2000 cycles
    repeat (4000) begin
      @(posedge clk);
      #1;
      h += (al === 1'b1);
    end
    chk(h >= 1990 && h <= 2010 && wl === 1'b0, 1);
    wr(OFS_CMD, 32'h1);
    cyc(2);
    sts(1'b0, CLS_ALARM, 8'h07);
    @(posedge clk) ov <= 1'b0;
    wr(OFS_CMD, 32'h1);
    cyc(2);
    sts(1'b1, CLS_NONE, 8'h00);
  endtask
  task automatic t_uv();
    int t;
    wr(OFS_UVD, 32'h2);
    wr(OFS_CFG, 32'h400);
    @(posedge clk) aux <= 1'b1;
    uv <= 1'b1;
    cyc(40);
    chk(en, 1);
    @(posedge clk) aux <= 1'b0;
    wt(CLS_ALARM, 8'h08, 20, t);
    @(posedge clk) uv <= 1'b0;
    wt(CLS_NONE, 8'h00, 5, t);
    wr(OFS_CFG, 32'h0);
  endtask
  task automatic t_inv();
    int t;
    logic [31:0] r;
    logic e;
    @(posedge clk) inv <= 1'b1;
    wt(CLS_WARN, 8'h09, 4500, t);
    wt(CLS_ALARM, 8'h09, 150, t);
    chk(t >= 60 && t <= 100, 1);
    @(posedge clk) inv <= 1'b0;
    u_host.key();
    cyc(2);
    sts(1'b0, CLS_ALARM, 8'h09);
    @(posedge clk) dig <= 1'b1;
    wt(CLS_NONE, 8'h00, 600, t);
    @(posedge clk) dig <= 1'b0;
    rw(1'b0, OFS_LOAD, 32'h0, r, e);
    chk(r[6:0], PCT_RESET - 7'h01);
  endtask
  task automatic t_mot();
    int t;
    // Trip option: warning above 90, trip at 100
    wr(OFS_CFG, 32'h20);
    @(posedge clk) mot <= 1'b1;
    wt(CLS_WARN, 8'h0A, 4000, t);
    wt(CLS_ALARM, 8'h0A, 450, t);
    chk(t >= 350 && t <= 370, 1);
    @(posedge clk) mot <= 1'b0;
    @(posedge clk) dig <= 1'b1;
    // Back in run, a load above 90 still shows as a warning
    wt(CLS_WARN, 8'h0A, 100, t);
    chk(en, 1);
    @(posedge clk) dig <= 1'b0;
    wr(OFS_CFG, 32'h0);
  endtask
  task automatic t_peak();
    int t;
    // Second pass selects brake control
    for (int k = 0; k < 2; k++) begin
      if (k == 1) wr(OFS_CFG, 32'h200);
      @(posedge clk) peak <= 1'b1;
      wt(CLS_WARN, 8'h0D, 3, t);
      wt(CLS_ALARM, 8'h0D, 6100, t);
      chk(t >= 5990 && t <= 6010, 1);
      @(posedge clk) peak <= 1'b0;
      pulse_dig();
      cyc(2);
      sts(k == 1, k == 1 ? CLS_NONE : CLS_ALARM, k == 1 ? 8'h00 : 8'h0D);
      if (k == 0) begin
        u_host.key();
        cyc(2);
        sts(1'b1, CLS_NONE, 8'h00);
      end
    end
    wr(OFS_CFG, 32'h0);
  endtask
  task automatic t_lock();
    @(posedge clk) shrt <= 1'b1;
    cyc(2);
    sts(1'b0, CLS_LOCK, 8'h10);
    chk({wl, lk}, 2'b11);
    @(posedge clk) shrt <= 1'b0;
    u_host.key();
    wr(OFS_CMD, 32'h1);
    pulse_dig();
    cyc(2);
    sts(1'b0, CLS_LOCK, 8'h10);
    // Mains cycle with the retained lock flag
    @(posedge clk) rst_b <= 1'b0;
    lock_mem <= 1'b1;
    cyc(2);
    @(posedge clk) rst_b <= 1'b1;
    cyc(2);
    sts(1'b0, CLS_LOCK, 8'h00);
    @(posedge clk) lock_mem <= 1'b0;
    u_host.key();
    cyc(2);
    sts(1'b1, CLS_NONE, 8'h00);
  endtask
  // ************************************
  // Main sequence
  // ************************************
  initial begin
    repeat (12) @(posedge clk);
    rst_b <= 1'b1;
    cyc(2);
    sts(1'b1, CLS_NONE, 8'h00);
    t_regs();
    t_warn();
    t_cfg();
    t_ov();
    t_uv();
    t_inv();
    t_mot();
    t_peak();
    t_lock();
    summarize();
  end
endmodule
`default_nettype wire

// file: testbench/panel_host.sv
/*
  Operator panel and serial host model: APB master and reset key.
  Assumes the bench calls its tasks and a rising-edge clock.
*/
`timescale 1ns/100ps
`default_nettype none
module panel_host (
  input wire logic ref_clk_i,
  input wire logic [31:0] prdata_i,
  input wire logic pready_i,
  input wire logic pslverr_i,
  output logic psel_o,
  output logic penable_o,
  output logic pwrite_o,
  output logic [7:0] paddr_o,
  output logic [31:0] pwdata_o,
  output logic panel_reset_o
);
  // ************************************
  // Idle bus and released key
  // ************************************
  initial begin
    psel_o = 1'b0;
    penable_o = 1'b0;
    pwrite_o = 1'b0;
    paddr_o = 8'h00;
    pwdata_o = 32'h0000_0000;
    panel_reset_o = 1'b0;
  end
  // Serial transfer; st is {timeout, slave error}
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
    output logic [31:0] rd, output logic [1:0] st);
    int i;
    @(posedge ref_clk_i);
    psel_o <= 1'b1;
    pwrite_o <= w;
    paddr_o <= a;
    pwdata_o <= d;
    @(posedge ref_clk_i);
    penable_o <= 1'b1;
    // Pre-edge values are read, so pready is taken at the edge
    for (i = 0; i < 20; i++) begin
      @(posedge ref_clk_i);
      if (pready_i === 1'b1) break;
    end
    rd = prdata_i;
    st = {i == 20, pslverr_i};
    psel_o <= 1'b0;
    penable_o <= 1'b0;
    // Released address and data lines show the inverse, never the last value
    paddr_o <= ~a;
    pwdata_o <= ~d;
  endtask
  // Panel reset key, held for one cycle
  task automatic key();
    @(posedge ref_clk_i);
    panel_reset_o <= 1'b1;
    @(posedge ref_clk_i);
    panel_reset_o <= 1'b0;
  endtask
endmodule
`default_nettype wire
